// File: hdl/mdfl_pkg.sv
// ****************************************************************
// shared constants of the fault latch block
// ****************************************************************
package mdfl_pkg;

    // ****************************************************************
    // clocking and filter timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;      // ref_clk_i period, 100 MHz
    localparam int OSC_NOMINAL_KHZ = 4000;  // nominal oscillator rate
    localparam int FILT_TIME_NS = 2000;     // least stable time before a change counts
    // least time rounds up to whole cycles
    localparam int FILT_CYCLES = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_CW = 16;            // filter counter width
    localparam logic [FILT_CW-1:0] FILT_CNT_MAX = FILT_CW'(FILT_CYCLES - 1);

    // ****************************************************************
    // serial frame layout
    // ****************************************************************
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam int NUM_DRV = 12;            // six high side, six low side
    localparam int NUM_BRIDGE = 6;
    localparam int BIT_ALL_CLR = 0;         // pairs with bit 15 for full reset
    localparam int BIT_CTRL_LSB = 1;
    localparam int BIT_CTRL_MSB = 12;
    localparam int BIT_OC = 13;             // overcurrent flag / clear
    localparam int BIT_OT = 14;             // thermal flag / clear
    localparam int BIT_OV = 15;             // overvoltage flag / clear

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FAULT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_DRIVE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FRAME = 8'h14;

    // control register fields
    localparam int CTRL_STANDBY = 0;
    localparam logic CTRL_RESET = 1'h0;

    // interrupt status / mask fields
    localparam int IRQ_W = 4;
    localparam int IRQ_OC = 0;
    localparam int IRQ_OT = 1;
    localparam int IRQ_OV = 2;
    localparam int IRQ_FRAME = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    // fault register fields
    localparam int FLT_OT_FLAG = 12;
    localparam int FLT_OV_FLAG = 13;
    localparam int FLT_OT_ACT = 14;
    localparam int FLT_OV_ACT = 15;

    // drive register field
    localparam int DRV_ON_LSB = 16;

    // serial receiver states, one-hot
    typedef enum logic [1:0] {
        SPI_IDLE = 2'h1,
        SPI_ACTIVE = 2'h2
    } mdfl_spi_state_t;

endpackage

// File: hdl/mdfl_filt_if.sv
`timescale 1ns/100ps
// ****************************************************************
// carrier between the latch core and one chatter filter
// ****************************************************************
interface mdfl_filt_if;
    logic raw;     // detector level straight from the pin
    logic hold;    // forces the filter inactive
    logic level;   // filtered indication

    modport filter (input raw, input hold, output level);
    modport core (output raw, output hold, input level);
endinterface

// File: hdl/mdfl_filter.sv
`timescale 1ns/100ps
// ****************************************************************
// two-flop synchroniser followed by a stability filter
// ****************************************************************
module mdfl_filter (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    mdfl_filt_if.filter fif
);
    import mdfl_pkg::*;
    logic meta_reg;              // first stage, read only by sync_reg
    logic sync_reg;              // second stage
    logic level_reg;             // accepted level
    logic [FILT_CW-1:0] cnt_reg; // cycles the new level has stood

    assign fif.level = level_reg;

    // synchroniser; no logic looks at the first stage
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            meta_reg <= 1'h0;
            sync_reg <= 1'h0;
        end else begin
            meta_reg <= fif.raw;
            sync_reg <= meta_reg;
        end
    end

    // a change is accepted only after it stood the whole filter time,
    // so short spikes on detect and on release are both swallowed
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || fif.hold) begin
            level_reg <= 1'h0;
            cnt_reg <= '0;
        end else if (sync_reg != level_reg) begin
            if (cnt_reg == FILT_CNT_MAX) begin
                level_reg <= sync_reg;
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + FILT_CW'(1);
            end
        end else begin
            cnt_reg <= '0; // bounce back restarts the count
        end
    end
endmodule

// File: hdl/mdfl_top.sv
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
module mdfl_top (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // serial link from the controller
    input wire logic chip_select_n_i,
    input wire logic spi_clk_i,
    input wire logic spi_data_i,
    output logic spi_data_o,
    output logic spi_data_oe_n_o,
    // analog detector levels, asynchronous
    input wire logic [mdfl_pkg::NUM_DRV-1:0] overcurrent_det_i,
    input wire logic overtemp_det_i,
    input wire logic overvoltage_det_i,
    // driver gate enables, low means high impedance
    output logic [mdfl_pkg::NUM_DRV-1:0] drv_on_o,
    // register port
    input wire logic [mdfl_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o
);
    import mdfl_pkg::*;
    // ****************************************************************
    // declarations
    // ****************************************************************
    logic cs_meta_reg, cs_sync_reg, cs_prev_reg;     // chip select sampling
    logic sck_meta_reg, sck_sync_reg, sck_prev_reg;  // serial clock sampling
    logic sdi_meta_reg, sdi_sync_reg;                // serial data sampling
    mdfl_spi_state_t spi_state_reg;                  // receiver state
    logic [FRAME_BITS-1:0] rx_shift_reg;             // incoming word
    logic [4:0] rx_count_reg;                        // bits received
    logic [FRAME_BITS-1:0] tx_shift_reg;             // outgoing word
    logic so_reg, so_oe_n_reg;                       // serial output pin
    logic [FRAME_BITS-1:0] last_frame_reg;           // last accepted word
    logic [NUM_DRV-1:0] setting_reg;                 // control bits 1..12
    logic [NUM_DRV-1:0] oc_latch_reg;                // per-driver trip latch
    logic ot_flag_reg, ov_flag_reg;                  // sticky status flags
    logic [NUM_DRV-1:0] drv_on_reg;                  // output enables
    logic ctrl_standby_reg;                          // standby request
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg;    // interrupt registers
    logic irq_reg;
    logic [31:0] rdata_reg;
    logic [NUM_DRV-1:0] oc_level;                    // filtered overcurrent
    logic ot_level, ov_level;                        // filtered thermal, voltage
    logic cs_rise, cs_fall, sck_rise, sck_fall;      // sampled edges
    logic frame_done;                                // full frame ended
    logic full_reset, oc_clear, ot_clear, ov_clear;  // frame-end commands
    logic [FRAME_BITS-1:0] status_word;              // word sent back
    logic [IRQ_W-1:0] irq_event;
    logic [NUM_DRV-1:0] drv_allow;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // full status reset needs both end bits set in one word
    function automatic logic is_full_reset(input logic [FRAME_BITS-1:0] w);
        is_full_reset = w[BIT_ALL_CLR] & w[BIT_OV];
    endfunction

    // register select, used by both read and write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // ****************************************************************
    // chatter filters: twelve drivers, thermal, overvoltage
    // ****************************************************************
    // the filters count on ref_clk_i, which stands for the internal
    // oscillator; all fault timing is derived from it alone
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DRV + 2; gi++) begin : g_filt
            mdfl_filt_if fif ();
            // standby holds every detector inactive
            assign fif.hold = ctrl_standby_reg;
            if (gi < NUM_DRV) begin : g_oc
                assign fif.raw = overcurrent_det_i[gi];
                assign oc_level[gi] = fif.level;
            end else if (gi == NUM_DRV) begin : g_ot
                assign fif.raw = overtemp_det_i;
                assign ot_level = fif.level;
            end else begin : g_ov
                assign fif.raw = overvoltage_det_i;
                assign ov_level = fif.level;
            end
            // stable-count filter on detect and release
            mdfl_filter u_filt (
                .ref_clk_i(ref_clk_i),
                .reset_n_i(reset_n_i),
                .fif(fif.filter)
            );
        end
    endgenerate

    // ****************************************************************
    // link sampling
    // ****************************************************************
    // every link pin passes two flops; edges are found past the second
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cs_meta_reg <= 1'h1;
            cs_sync_reg <= 1'h1;
            cs_prev_reg <= 1'h1;
            sck_meta_reg <= 1'h0;
            sck_sync_reg <= 1'h0;
            sck_prev_reg <= 1'h0;
            sdi_meta_reg <= 1'h0;
            sdi_sync_reg <= 1'h0;
        end else begin
            cs_meta_reg <= chip_select_n_i;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            sck_meta_reg <= spi_clk_i;
            sck_sync_reg <= sck_meta_reg;
            sck_prev_reg <= sck_sync_reg;
            sdi_meta_reg <= spi_data_i;
            sdi_sync_reg <= sdi_meta_reg;
        end
    end

    assign cs_rise = cs_sync_reg & ~cs_prev_reg;
    assign cs_fall = ~cs_sync_reg & cs_prev_reg;
    assign sck_rise = sck_sync_reg & ~sck_prev_reg;
    assign sck_fall = ~sck_sync_reg & sck_prev_reg;

    // ****************************************************************
    // frame receiver
    // ****************************************************************
    // a frame counts only with exactly sixteen bits; a short or long one
    // is dropped so a glitch on the clock line cannot act as a command
    assign frame_done = (spi_state_reg == SPI_ACTIVE) && cs_rise && (rx_count_reg == FRAME_LEN);

    // commands decoded on the rising chip select edge
    assign full_reset = frame_done & is_full_reset(rx_shift_reg);
    assign oc_clear = full_reset | (frame_done & rx_shift_reg[BIT_OC]);
    assign ot_clear = full_reset | (frame_done & rx_shift_reg[BIT_OT]);
    assign ov_clear = full_reset | (frame_done & rx_shift_reg[BIT_OV]);

    // receiver state and bit shifter; standby drops any frame in flight
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || ctrl_standby_reg) begin
            spi_state_reg <= SPI_IDLE;
            rx_shift_reg <= '0;
            rx_count_reg <= '0;
        end else begin
            case (spi_state_reg)
                SPI_IDLE: begin
                    if (cs_fall) begin
                        spi_state_reg <= SPI_ACTIVE;
                        rx_count_reg <= '0;
                    end
                end
                SPI_ACTIVE: begin
                    if (cs_rise) begin
                        spi_state_reg <= SPI_IDLE;
                    end else if (sck_rise) begin
                        // most significant bit travels first
                        rx_shift_reg <= {rx_shift_reg[FRAME_BITS-2:0], sdi_sync_reg};
                        if (rx_count_reg != 5'h1F) begin
                            rx_count_reg <= rx_count_reg + 5'h01;
                        end
                    end
                end
                default: begin
                    spi_state_reg <= SPI_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // status word and serial output
    // ****************************************************************
    always_comb begin
        status_word = '0;
        status_word[BIT_OC] = |oc_latch_reg;
        status_word[BIT_OT] = ot_flag_reg;
        status_word[BIT_OV] = ov_flag_reg;
    end

    // status is captured at frame start and shifted out on falling clock
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || ctrl_standby_reg) begin
            tx_shift_reg <= '0;
            so_reg <= 1'h0;
            so_oe_n_reg <= 1'h1;
        end else if (cs_fall && spi_state_reg == SPI_IDLE) begin
            tx_shift_reg <= {status_word[FRAME_BITS-2:0], 1'h0};
            so_reg <= status_word[FRAME_BITS-1];
            so_oe_n_reg <= 1'h0;
        end else if (spi_state_reg == SPI_ACTIVE && cs_rise) begin
            so_oe_n_reg <= 1'h1;
        end else if (spi_state_reg == SPI_ACTIVE && sck_fall) begin
            so_reg <= tx_shift_reg[FRAME_BITS-1];
            tx_shift_reg <= {tx_shift_reg[FRAME_BITS-2:0], 1'h0};
        end
    end

    // ****************************************************************
    // settings and fault latches
    // ****************************************************************
    // settings: full reset forces all off and ignores bits 1-12, any
    // other frame (with or without the overcurrent clear) applies them
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || ctrl_standby_reg) begin
            setting_reg <= '0;
            last_frame_reg <= '0;
        end else if (full_reset) begin
            setting_reg <= '0;
            last_frame_reg <= rx_shift_reg;
        end else if (frame_done) begin
            setting_reg <= rx_shift_reg[BIT_CTRL_MSB:BIT_CTRL_LSB];
            last_frame_reg <= rx_shift_reg;
        end
    end

    // per-driver trip latch: a set in the clearing cycle wins, so a
    // persisting fault re-trips at once
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || ctrl_standby_reg) begin
            oc_latch_reg <= '0;
        end else begin
            oc_latch_reg <= oc_level | (oc_latch_reg & {NUM_DRV{~oc_clear}});
        end
    end

    // thermal and overvoltage flags stay set after recovery
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || ctrl_standby_reg) begin
            ot_flag_reg <= 1'h0;
            ov_flag_reg <= 1'h0;
        end else begin
            ot_flag_reg <= ot_level | (ot_flag_reg & ~ot_clear);
            ov_flag_reg <= ov_level | (ov_flag_reg & ~ov_clear);
        end
    end

    // ****************************************************************
    // driver enables
    // ****************************************************************
    // a half-bridge with both sides requested goes high impedance
    generate
        for (gi = 0; gi < NUM_BRIDGE; gi++) begin : g_bridge
            assign drv_allow[2*gi] = setting_reg[2*gi] & ~setting_reg[2*gi+1];
            assign drv_allow[2*gi+1] = setting_reg[2*gi+1] & ~setting_reg[2*gi];
        end
    endgenerate

    // thermal and overvoltage act on the live filtered level, so outputs
    // return by themselves; overcurrent acts on the latch of one driver
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || ctrl_standby_reg) begin
            drv_on_reg <= '0;
        end else if (ot_level || ov_level) begin
            drv_on_reg <= '0;
        end else begin
            drv_on_reg <= drv_allow & ~oc_latch_reg & ~oc_level;
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    assign irq_event[IRQ_OC] = |(oc_level & ~oc_latch_reg);
    assign irq_event[IRQ_OT] = ot_level & ~ot_flag_reg;
    assign irq_event[IRQ_OV] = ov_level & ~ov_flag_reg;
    assign irq_event[IRQ_FRAME] = frame_done;

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            irq_stat_reg <= IRQ_RESET;
        end else if (reg_wr_i && hit(reg_addr_i, OFS_IRQ_STAT)) begin
            irq_stat_reg <= irq_event | (irq_stat_reg & ~reg_wdata_i[IRQ_W-1:0]);
        end else begin
            irq_stat_reg <= irq_event | irq_stat_reg;
        end
    end

    // level interrupt from a flop
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            irq_reg <= 1'h0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ****************************************************************
    // register port
    // ****************************************************************
    // writable control and mask
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ctrl_standby_reg <= CTRL_RESET;
            irq_mask_reg <= IRQ_RESET;
        end else if (reg_wr_i) begin
            if (hit(reg_addr_i, OFS_CTRL)) begin
                ctrl_standby_reg <= reg_wdata_i[CTRL_STANDBY];
            end
            if (hit(reg_addr_i, OFS_IRQ_MASK)) begin
                irq_mask_reg <= reg_wdata_i[IRQ_W-1:0];
            end
        end
    end

    // read data stand one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            rdata_reg <= '0;
            if (hit(reg_addr_i, OFS_CTRL)) begin
                rdata_reg[CTRL_STANDBY] <= ctrl_standby_reg;
            end else if (hit(reg_addr_i, OFS_IRQ_STAT)) begin
                rdata_reg[IRQ_W-1:0] <= irq_stat_reg;
            end else if (hit(reg_addr_i, OFS_IRQ_MASK)) begin
                rdata_reg[IRQ_W-1:0] <= irq_mask_reg;
            end else if (hit(reg_addr_i, OFS_FAULT)) begin
                rdata_reg[NUM_DRV-1:0] <= oc_latch_reg;
                rdata_reg[FLT_OT_FLAG] <= ot_flag_reg;
                rdata_reg[FLT_OV_FLAG] <= ov_flag_reg;
                rdata_reg[FLT_OT_ACT] <= ot_level;
                rdata_reg[FLT_OV_ACT] <= ov_level;
            end else if (hit(reg_addr_i, OFS_DRIVE)) begin
                rdata_reg[NUM_DRV-1:0] <= setting_reg;
                rdata_reg[DRV_ON_LSB+NUM_DRV-1:DRV_ON_LSB] <= drv_on_reg;
            end else if (hit(reg_addr_i, OFS_FRAME)) begin
                rdata_reg[FRAME_BITS-1:0] <= last_frame_reg;
            end
        end else begin
            rdata_reg <= '0;
        end
    end

    // ****************************************************************
    // outputs, all from flops
    // ****************************************************************
    assign spi_data_o = so_reg;
    assign spi_data_oe_n_o = so_oe_n_reg;
    assign drv_on_o = drv_on_reg;
    assign reg_rdata_o = rdata_reg;
    assign irq_o = irq_reg;
endmodule

// File: tb/mdfl_checker.sv
`timescale 1ns/100ps
// ****************************************************************
// port-level checks of the fault latch
// ****************************************************************
module mdfl_checker (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic chip_select_n_i,
    input wire logic spi_data_oe_n_o,
    input wire logic [mdfl_pkg::NUM_DRV-1:0] overcurrent_det_i,
    input wire logic overtemp_det_i,
    input wire logic overvoltage_det_i,
    input wire logic [mdfl_pkg::NUM_DRV-1:0] drv_on_o,
    input wire logic [mdfl_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic irq_o
);
    import mdfl_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [15:0] oc_cnt, ot_cnt, ov_cnt; // cycles each detector has stood active and unchanged
    logic [NUM_DRV-1:0] oc_last;
    // restart with the filters: a reset or any control write may clear them
    always_ff @(posedge ref_clk_i) begin
        oc_last <= overcurrent_det_i;
        if (!reset_n_i || (reg_wr_i && reg_addr_i == OFS_CTRL)) begin
            oc_cnt <= 16'h0;
            ot_cnt <= 16'h0;
            ov_cnt <= 16'h0;
        end else begin
            oc_cnt <= (overcurrent_det_i != oc_last || overcurrent_det_i == '0) ?
                16'h0 : oc_cnt + 16'h1;
            ot_cnt <= overtemp_det_i ? ot_cnt + 16'h1 : 16'h0;
            ov_cnt <= overvoltage_det_i ? ov_cnt + 16'h1 : 16'h0;
        end
    end
    a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its slot");
    a_oe_idle: assert property (chip_select_n_i [*8] |-> spi_data_oe_n_o)
        else $error("serial output driven while deselected");
    a_oe_start: assert property ($fell(spi_data_oe_n_o) |-> !$past(chip_select_n_i, 2))
        else $error("serial output enabled without select");
    a_oc_cut_off: assert property (oc_cnt >= 16'h00D2 |->
        (drv_on_o & overcurrent_det_i) == '0)
        else $error("overcurrent driver still on");
    a_ot_all_off: assert property (ot_cnt >= 16'h00D2 |-> drv_on_o == '0)
        else $error("driver on while hot");
    a_ov_all_off: assert property (ov_cnt >= 16'h00D2 |-> drv_on_o == '0)
        else $error("driver on during overvoltage");
    a_bridge_pair: assert property ((drv_on_o & (drv_on_o >> 1) & 12'h555) == '0)
        else $error("both sides of a bridge on");
    a_standby_off: assert property (reg_wr_i && reg_addr_i == OFS_CTRL && reg_wdata_i[0] |->
        ##3 drv_on_o == '0)
        else $error("driver on in standby");
    a_irq_masked: assert property (reg_wr_i && reg_addr_i == OFS_IRQ_MASK &&
        reg_wdata_i[3:0] == 4'h0 |-> ##2 !irq_o)
        else $error("interrupt with all masked");
    cover property (oc_cnt == 16'h00D2);
    cover property (ot_cnt == 16'h00D2);
    cover property ($fell(spi_data_oe_n_o));
endmodule
bind mdfl_top mdfl_checker chk_i (.ref_clk_i, .reset_n_i, .chip_select_n_i, .spi_data_oe_n_o,
    .overcurrent_det_i, .overtemp_det_i, .overvoltage_det_i, .drv_on_o, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);

// File: tb/mdfl_mcu.sv
`timescale 1ns/100ps
// serial master standing for the controller; idle levels follow the pin pulls
module mdfl_mcu (
    output logic chip_select_n_o,
    output logic spi_clk_o,
    output logic spi_data_o,
    input wire logic spi_data_i
);
    initial begin
        chip_select_n_o = 1'b1;
        spi_clk_o = 1'b0;
        spi_data_o = 1'b0;
    end
    // one frame msb first, status sampled on each rising serial clock
    task automatic xfer(input logic [15:0] w, output logic [15:0] st);
        #2; // keep every pin change off the sampling edge
        chip_select_n_o = 1'b0;
        #250;
        for (int i = 15; i >= 0; i--) begin
            spi_data_o = w[i];
            #62.5;
            spi_clk_o = 1'b1;
            st[i] = spi_data_i;
            #62.5;
            spi_clk_o = 1'b0;
        end
        #62.5;
        spi_data_o = 1'b0;
        chip_select_n_o = 1'b1;
        #500;
    endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
    import mdfl_pkg::*;
    localparam logic [15:0] W_SET = 16'h0AAA; // high sides of all bridges on
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, ot = 1'b0, ov = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
    logic cs_n, sclk, sdi, sdo, oe_n, irq;
    logic [11:0] oc = 12'h000, drv;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] st;
    int err_count = 0, tests_run = 0, cyc = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    mdfl_top DUT (.ref_clk_i, .reset_n_i, .chip_select_n_i(cs_n), .spi_clk_i(sclk),
        .spi_data_i(sdi), .spi_data_o(sdo), .spi_data_oe_n_o(oe_n), .overcurrent_det_i(oc),
        .overtemp_det_i(ot), .overvoltage_det_i(ov), .drv_on_o(drv), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .irq_o(irq));
    // a released output shows the inverse, so a late or missing enable is caught
    mdfl_mcu mcu (.chip_select_n_o(cs_n), .spi_clk_o(sclk), .spi_data_o(sdi),
        .spi_data_i(oe_n ? ~sdo : sdo));
    task conclude;
        if (err_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task wt(input int n); repeat (n) @(posedge ref_clk_i); endtask
    task dchk(input logic [11:0] e); chk(32'(drv), 32'(e)); endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        {wr_s, addr, wdata} <= {1'b1, a, d};
        @(posedge ref_clk_i);
        wr_s <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        {rd_s, addr} <= {1'b1, a};
        @(posedge ref_clk_i);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task frame(input logic [15:0] w, input logic [15:0] e);
        mcu.xfer(w, st);
        wt(10);
        chk(32'(st), 32'(e));
    endtask
    // hang guard, far above the roughly 7k cycles the sequence needs
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        wt(4);
        reset_n_i <= 1'b1;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_IRQ_MASK, 32'h0);
        rd(8'h3C, 32'h0);
        frame(W_SET, 16'h0000);
        dchk(12'h555);
        oc <= 12'h002; wt(150); oc <= 12'h000; wt(300); dchk(12'h555);
        oc <= 12'h001; wt(300); dchk(12'h554);
        oc <= 12'h000; wt(300); dchk(12'h554);
        frame(W_SET, 16'h2000);
        frame(W_SET | 16'h2000, 16'h2000); dchk(12'h555);
        oc <= 12'h001; wt(300); frame(W_SET | 16'h2000, 16'h2000); dchk(12'h554);
        oc <= 12'h000; wt(300); frame(W_SET | 16'h2000, 16'h2000); dchk(12'h555);
        ot <= 1'b1; wt(300); dchk(12'h000);
        ot <= 1'b0; wt(300); dchk(12'h555);
        frame(W_SET | 16'h4000, 16'h4000);
        frame(W_SET, 16'h0000);
        ov <= 1'b1; oc <= 12'h004; wt(300); dchk(12'h000);
        ov <= 1'b0; oc <= 12'h000; wt(300); dchk(12'h551);
        rd(OFS_FAULT, 32'h2004);
        frame(W_SET | 16'h8001, 16'hA000); dchk(12'h000);
        frame(W_SET, 16'h0000); dchk(12'h555);
        wr(OFS_CTRL, 32'h1); wt(5); dchk(12'h000);
        ot <= 1'b1; mcu.xfer(W_SET, st); wt(300); ot <= 1'b0; wt(5);
        chk(32'(st), 32'hFFFF);
        wr(OFS_CTRL, 32'h0); wt(5); dchk(12'h000);
        frame(W_SET, 16'h0000); dchk(12'h555);
        frame(W_SET | 16'h0004, 16'h0000); dchk(12'h554);
        chk(32'(irq), 32'h0);
        wr(OFS_IRQ_MASK, 32'hF); wt(3); chk(32'(irq), 32'h1);
        wr(OFS_IRQ_STAT, 32'hF); wt(3); chk(32'(irq), 32'h0);
        rd(OFS_IRQ_STAT, 32'h0);
        wr(OFS_IRQ_MASK, 32'h0);
        wt(5);
        conclude();
    end
endmodule
